// ### monitor_irq_cfg.svh
// Offsets, bit positions, reset values and timing counts of the mask bank
`ifndef MONITOR_IRQ_CFG_SVH
`define MONITOR_IRQ_CFG_SVH

// Register offsets
`define ANALOG_MASK_OFS 8'h19
`define TACH_MASK_OFS 8'h1a
`define MISC_MASK_OFS 8'h1b
`define GP_LOW_MASK_OFS 8'h1c
`define GP_HIGH_MASK_OFS 8'h1d
`define TEMP_OFFSET_OFS 8'h1e
`define TEMP_READING_OFS 8'h1f

// Reset value shared by every register of the bank
`define BANK_RESET_VAL 8'h00

// Field positions inside the misc source mask
`define MISC_DIE_TEMP_BIT 0
`define MISC_BATTERY_BIT 1
`define MISC_ANALOG_8_BIT 2
`define MISC_THERMAL_BIT 3
`define MISC_AUTO_FAN_BIT 4
`define MISC_UNUSED_BIT 5
`define MISC_CHASSIS_BIT 6
`define MISC_GP_PIN_16_BIT 7

// Bits of the misc mask that hold storage
`define MISC_WRITABLE 8'hdf

// Cycles from a raw sample strobe to the updated reading
`define TEMP_UPDATE_CYCLES 2

// Cycles from a flag or mask change to the interrupt output
`define IRQ_LATENCY_CYCLES 1

`endif

// ### monitor_irq_pkg.sv
// Types shared by the interrupt mask bank modules
package monitor_irq_pkg;

  typedef struct packed {
    logic [7:0] analog;
    logic [7:0] tach;
    logic [7:0] misc;
    logic [7:0] gp_low;
    logic [7:0] gp_high;
  } mask_set_t;

  typedef struct packed {
    logic [7:0] analog;
    logic [7:0] tach;
    logic die_temp;
    logic battery;
    logic analog_8;
    logic thermal;
    logic auto_fan;
    logic chassis;
    logic [16:0] gp_pin;
  } event_set_t;

  typedef enum logic [1:0] {
    CAP_IDLE = 2'b01,
    CAP_APPLY = 2'b10
  } cap_state_t;

endpackage

// ### mask_gate_if.sv
// Carrier between the register bank and the interrupt gate
interface mask_gate_if;
  monitor_irq_pkg::mask_set_t masks;
  monitor_irq_pkg::event_set_t events;
  logic irq_any;
  logic [38:0] unmasked;

  modport bank (
    output masks,
    output events,
    input irq_any,
    input unmasked
  );

  modport gate (
    input masks,
    input events,
    output irq_any,
    output unmasked
  );
endinterface

// ### irq_gate.sv
// Combines source flags with their mask bits into one interrupt request
`include "monitor_irq_cfg.svh"

module irq_gate (
  // Masks and flags in, request out
  mask_gate_if.gate gi
);

  logic [7:0] misc_flags;

  assign misc_flags = {gi.events.gp_pin[16],
                       gi.events.chassis,
                       1'b0,
                       gi.events.auto_fan,
                       gi.events.thermal,
                       gi.events.analog_8,
                       gi.events.battery,
                       gi.events.die_temp};

  // Flags pass untouched; only the request is gated
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_gate
      assign gi.unmasked[i] = gi.events.analog[i] & ~gi.masks.analog[i];
      assign gi.unmasked[8 + i] = gi.events.tach[i] & ~gi.masks.tach[i];
      assign gi.unmasked[16 + i] = gi.events.gp_pin[i] &
                                   ~gi.masks.gp_low[i];
      assign gi.unmasked[24 + i] = gi.events.gp_pin[8 + i] &
                                   ~gi.masks.gp_high[i];
    end
    // [R3] [R4] [R5] [R7] [R8] misc sources, bit 5 skipped
    for (i = 0; i < 7; i = i + 1) begin : g_misc
      localparam int MB = (i < `MISC_UNUSED_BIT) ? i : i + 1;
      assign gi.unmasked[32 + i] = misc_flags[MB] & ~gi.masks.misc[MB];
    end
  endgenerate

  assign gi.irq_any = |gi.unmasked;

endmodule

// ### temp_offset_adder.sv
// Signed addition of the calibration offset with saturation
module temp_offset_adder #(
  parameter int WIDTH = 8
) (
  // Operands
  input wire logic [WIDTH-1:0] raw,
  input wire logic [WIDTH-1:0] offset,
  // Result
  output logic [WIDTH-1:0] sum
);

  logic [WIDTH:0] wide;
  logic ovf;

  // Sign-extend both so the carry shows overflow
  assign wide = {raw[WIDTH-1], raw} + {offset[WIDTH-1], offset};
  assign ovf = wide[WIDTH] ^ wide[WIDTH-1];

  // Clamp instead of wrapping, so a hot die never reads cold
  always_comb begin
    if (!ovf) begin
      sum = wide[WIDTH-1:0];
    end else if (wide[WIDTH]) begin
      sum = {1'b1, {(WIDTH-1){1'b0}}};
    end else begin
      sum = {1'b0, {(WIDTH-1){1'b1}}};
    end
  end

endmodule

// ### monitor_interrupt_mask_bank.sv
// Interrupt mask registers and internal temperature offset of a monitor
//
// What this block does
// [R1] Offset 0x19 masks analog inputs 0 to 7, bit n for input n, 1 masks.
// [R2] Offset 0x1a masks tachometer channels 0 to 7, bit n for channel n.
// [R3] Offset 0x1b bits 0, 1, 2 mask die temp, battery and analog input 8.
// [R4] Offset 0x1b bit 3 set suppresses thermal-limit interrupts.
// [R5] Offset 0x1b bit 4 set suppresses automatic fan control interrupts.
// [R6] Offset 0x1b bit 5 is unused and always reads back 0.
// [R7] Offset 0x1b bit 6 set suppresses chassis intrusion interrupts.
// [R8] Offset 0x1b bit 7 set suppresses general-purpose pin 16 interrupts.
// [R9] Offset 0x1c masks general-purpose pins 0 to 7, bit n for pin n.
// [R10] Offset 0x1d masks general-purpose pins 8 to 15, bit n for pin n+8.
// [R11] Offset 0x1e is a signed offset added to each die temperature result.
// [R12] Offset 0x1f is read-only and shows the latest corrected reading.
// [R13] Power-on reset clears all mask, offset and reading registers.
// [R14] Interrupt rises only for a flagged source whose mask bit is 0.
`include "monitor_irq_cfg.svh"

module monitor_interrupt_mask_bank #(
  parameter int TEMP_WIDTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port from the serial interface engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  output logic reg_addr_hit,
  // Source status flags, held by the status logic
  input wire logic [7:0] analog_input_flag,
  input wire logic [7:0] tach_flag,
  input wire logic die_temp_flag,
  input wire logic battery_flag,
  input wire logic analog_input_8_flag,
  input wire logic thermal_limit_event,
  input wire logic auto_fan_ctrl,
  input wire logic chassis_intrusion,
  input wire logic [16:0] gp_pin_flag,
  // Die temperature from the converter
  input wire logic [TEMP_WIDTH-1:0] raw_temp,
  input wire logic raw_temp_valid,
  output logic [TEMP_WIDTH-1:0] corrected_temp,
  output logic corrected_temp_valid,
  // Interrupt request
  output logic irq_out
);

  mask_gate_if gi ();

  logic [7:0] analog_input_irq_mask_reg;
  logic [7:0] tach_irq_mask_reg;
  logic [7:0] misc_source_irq_mask_reg;
  logic [7:0] gp_pin_low_irq_mask_reg;
  logic [7:0] gp_pin_high_irq_mask_reg;
  logic [TEMP_WIDTH-1:0] die_temp_offset_reg;
  logic [TEMP_WIDTH-1:0] die_temp_reading_reg;
  logic [TEMP_WIDTH-1:0] raw_hold_reg;
  logic [TEMP_WIDTH-1:0] temp_sum;
  logic [7:0] rdata_next;
  logic irq_reg;
  logic rd_valid_reg;
  logic [7:0] rdata_reg;
  logic hit_reg;
  logic temp_valid_reg;
  monitor_irq_pkg::cap_state_t cap_state_reg;
  monitor_irq_pkg::cap_state_t cap_state_next;

  // Decoding: wr_sel for the write path, bank_hit for the read hit flag
  function automatic logic wr_sel(input logic [7:0] a, input logic [7:0] o);
    wr_sel = (a == o);
  endfunction

  function automatic logic bank_hit(input logic [7:0] a);
    bank_hit = (a >= `ANALOG_MASK_OFS) && (a <= `TEMP_READING_OFS);
  endfunction

  // [R1] analog input mask store
  // [R13] cleared at reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      analog_input_irq_mask_reg <= `BANK_RESET_VAL;
    end else if (reg_wr_en && wr_sel(reg_addr, `ANALOG_MASK_OFS)) begin
      analog_input_irq_mask_reg <= reg_wdata;
    end
  end
  // [R2] tachometer mask store
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tach_irq_mask_reg <= `BANK_RESET_VAL;
    end else if (reg_wr_en && wr_sel(reg_addr, `TACH_MASK_OFS)) begin
      tach_irq_mask_reg <= reg_wdata;
    end
  end
  // [R3] [R4] [R5] [R6] [R7] [R8] misc store, bit 5 never kept
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      misc_source_irq_mask_reg <= `BANK_RESET_VAL;
    end else if (reg_wr_en && wr_sel(reg_addr, `MISC_MASK_OFS)) begin
      misc_source_irq_mask_reg <= reg_wdata & `MISC_WRITABLE;
    end
  end
  // [R9] low pin mask store
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gp_pin_low_irq_mask_reg <= `BANK_RESET_VAL;
    end else if (reg_wr_en && wr_sel(reg_addr, `GP_LOW_MASK_OFS)) begin
      gp_pin_low_irq_mask_reg <= reg_wdata;
    end
  end
  // [R10] high pin mask store
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gp_pin_high_irq_mask_reg <= `BANK_RESET_VAL;
    end else if (reg_wr_en && wr_sel(reg_addr, `GP_HIGH_MASK_OFS)) begin
      gp_pin_high_irq_mask_reg <= reg_wdata;
    end
  end
  // [R11] calibration offset store
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      die_temp_offset_reg <= `BANK_RESET_VAL;
    end else if (reg_wr_en && wr_sel(reg_addr, `TEMP_OFFSET_OFS)) begin
      die_temp_offset_reg <= reg_wdata[TEMP_WIDTH-1:0];
    end
  end
  // Sample is held so a converter glitch after the strobe is harmless
  always_comb begin
    cap_state_next = cap_state_reg;
    case (cap_state_reg)
      monitor_irq_pkg::CAP_IDLE: begin
        if (raw_temp_valid) begin
          cap_state_next = monitor_irq_pkg::CAP_APPLY;
        end
      end
      monitor_irq_pkg::CAP_APPLY: begin
        cap_state_next = monitor_irq_pkg::CAP_IDLE;
      end
      default: begin
        cap_state_next = monitor_irq_pkg::CAP_IDLE;
      end
    endcase
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cap_state_reg <= monitor_irq_pkg::CAP_IDLE;
    end else begin
      cap_state_reg <= cap_state_next;
    end
  end
  // A strobe during apply is dropped; the converter rate is far lower
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      raw_hold_reg <= '0;
    end else if (raw_temp_valid &&
                 cap_state_reg == monitor_irq_pkg::CAP_IDLE) begin
      raw_hold_reg <= raw_temp;
    end
  end
  temp_offset_adder #(
    .WIDTH(TEMP_WIDTH)
  ) u_adder (
    .raw(raw_hold_reg),
    .offset(die_temp_offset_reg),
    .sum(temp_sum)
  );
  // [R12] reading updated only by the converter path
  // [R11] offset applied before the reading is stored
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      die_temp_reading_reg <= `BANK_RESET_VAL;
      temp_valid_reg <= 1'b0;
    end else begin
      temp_valid_reg <= (cap_state_reg == monitor_irq_pkg::CAP_APPLY);
      if (cap_state_reg == monitor_irq_pkg::CAP_APPLY) begin
        die_temp_reading_reg <= temp_sum;
      end
    end
  end

  assign corrected_temp = die_temp_reading_reg;
  assign corrected_temp_valid = temp_valid_reg;

  // Read mux; reserved bit comes back as zero by construction
  always_comb begin
    rdata_next = `BANK_RESET_VAL;
    case (reg_addr)
      `ANALOG_MASK_OFS: rdata_next = analog_input_irq_mask_reg;
      `TACH_MASK_OFS: rdata_next = tach_irq_mask_reg;
      `MISC_MASK_OFS: rdata_next = misc_source_irq_mask_reg;
      `GP_LOW_MASK_OFS: rdata_next = gp_pin_low_irq_mask_reg;
      `GP_HIGH_MASK_OFS: rdata_next = gp_pin_high_irq_mask_reg;
      `TEMP_OFFSET_OFS: rdata_next = 8'(die_temp_offset_reg);
      `TEMP_READING_OFS: rdata_next = 8'(die_temp_reading_reg);
      default: rdata_next = `BANK_RESET_VAL;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= `BANK_RESET_VAL;
      rd_valid_reg <= 1'b0;
      hit_reg <= 1'b0;
    end else begin
      rd_valid_reg <= reg_rd_en;
      if (reg_rd_en) begin
        rdata_reg <= rdata_next;
        hit_reg <= bank_hit(reg_addr);
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rd_valid = rd_valid_reg;
  assign reg_addr_hit = hit_reg;

  // Masks and flags to the gate
  assign gi.masks.analog = analog_input_irq_mask_reg;
  assign gi.masks.tach = tach_irq_mask_reg;
  assign gi.masks.misc = misc_source_irq_mask_reg;
  assign gi.masks.gp_low = gp_pin_low_irq_mask_reg;
  assign gi.masks.gp_high = gp_pin_high_irq_mask_reg;
  assign gi.events.analog = analog_input_flag;
  assign gi.events.tach = tach_flag;
  assign gi.events.die_temp = die_temp_flag;
  assign gi.events.battery = battery_flag;
  assign gi.events.analog_8 = analog_input_8_flag;
  assign gi.events.thermal = thermal_limit_event;
  assign gi.events.auto_fan = auto_fan_ctrl;
  assign gi.events.chassis = chassis_intrusion;
  assign gi.events.gp_pin = gp_pin_flag;

  irq_gate u_gate (
    .gi(gi.gate)
  );

  // [R14] registered request from unmasked flags
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= gi.irq_any;
    end
  end
  assign irq_out = irq_reg;
  property p_analog_mask;
    @(posedge sys_clk) disable iff (rst)
    (analog_input_irq_mask_reg[0] && tach_flag == 8'h00 &&
     analog_input_flag == 8'h01 && !die_temp_flag && !battery_flag &&
     !analog_input_8_flag && !thermal_limit_event && !auto_fan_ctrl &&
     !chassis_intrusion && gp_pin_flag == 17'h00000) |=> !irq_out;
  endproperty
  a_analog_mask: assert property (p_analog_mask) // [R1]
    else $error("Masked analog input raised the interrupt");
  property p_tach_unmasked;
    @(posedge sys_clk) disable iff (rst)
    (|(tach_flag & ~tach_irq_mask_reg)) |=> irq_out;
  endproperty
  a_tach_unmasked: assert property (p_tach_unmasked) // [R2]
    else $error("Unmasked tach flag did not raise the interrupt");
  property p_die_temp_unmasked;
    @(posedge sys_clk) disable iff (rst)
    (die_temp_flag && !misc_source_irq_mask_reg[`MISC_DIE_TEMP_BIT])
      |=> irq_out;
  endproperty
  a_die_temp_unmasked: assert property (p_die_temp_unmasked) // [R3]
    else $error("Unmasked die temperature flag lost");
  property p_thermal_unmasked;
    @(posedge sys_clk) disable iff (rst)
    (thermal_limit_event && !misc_source_irq_mask_reg[`MISC_THERMAL_BIT])
      |=> irq_out;
  endproperty
  a_thermal_unmasked: assert property (p_thermal_unmasked) // [R4]
    else $error("Unmasked thermal event lost");
  property p_fan_unmasked;
    @(posedge sys_clk) disable iff (rst)
    (auto_fan_ctrl && !misc_source_irq_mask_reg[`MISC_AUTO_FAN_BIT])
      |=> irq_out;
  endproperty
  a_fan_unmasked: assert property (p_fan_unmasked) // [R5]
    else $error("Unmasked fan control event lost");
  property p_unused_zero;
    @(posedge sys_clk) disable iff (rst)
    (reg_rd_en && reg_addr == `MISC_MASK_OFS)
      |=> reg_rd_valid && !reg_rdata[`MISC_UNUSED_BIT];
  endproperty
  a_unused_zero: assert property (p_unused_zero) // [R6]
    else $error("Unused mask bit read back as one");
  property p_chassis_unmasked;
    @(posedge sys_clk) disable iff (rst)
    (chassis_intrusion && !misc_source_irq_mask_reg[`MISC_CHASSIS_BIT])
      |=> irq_out;
  endproperty
  a_chassis_unmasked: assert property (p_chassis_unmasked) // [R7]
    else $error("Unmasked intrusion event lost");
  property p_pin16_unmasked;
    @(posedge sys_clk) disable iff (rst)
    (gp_pin_flag[16] && !misc_source_irq_mask_reg[`MISC_GP_PIN_16_BIT])
      |=> irq_out;
  endproperty
  a_pin16_unmasked: assert property (p_pin16_unmasked) // [R8]
    else $error("Unmasked pin 16 event lost");
  property p_gp_pins_unmasked;
    @(posedge sys_clk) disable iff (rst)
    (|(gp_pin_flag[15:0] &
       ~{gp_pin_high_irq_mask_reg, gp_pin_low_irq_mask_reg})) |=> irq_out;
  endproperty
  a_gp_pins_unmasked: assert property (p_gp_pins_unmasked) // [R9] [R10]
    else $error("Unmasked pin flag did not raise the interrupt");
  property p_offset_applied;
    @(posedge sys_clk) disable iff (rst)
    (raw_temp_valid && cap_state_reg == monitor_irq_pkg::CAP_IDLE &&
     !(reg_wr_en && reg_addr == `TEMP_OFFSET_OFS) && raw_temp == 8'h20 &&
     die_temp_offset_reg == 8'hfe)
      |=> ##1 corrected_temp == 8'h1e && corrected_temp_valid;
  endproperty
  a_offset_applied: assert property (p_offset_applied) // [R11]
    else $error("Offset not applied to the die reading");
  property p_reading_readonly;
    @(posedge sys_clk) disable iff (rst)
    (cap_state_reg != monitor_irq_pkg::CAP_APPLY)
      |=> $stable(die_temp_reading_reg);
  endproperty
  a_reading_readonly: assert property (p_reading_readonly) // [R12]
    else $error("Die reading changed without a conversion");
  property p_reset_clear;
    @(posedge sys_clk)
    $fell(rst) |-> (analog_input_irq_mask_reg == 8'h00 &&
      tach_irq_mask_reg == 8'h00 && misc_source_irq_mask_reg == 8'h00 &&
      gp_pin_low_irq_mask_reg == 8'h00 &&
      gp_pin_high_irq_mask_reg == 8'h00 &&
      die_temp_offset_reg == 8'h00 && die_temp_reading_reg == 8'h00);
  endproperty
  a_reset_clear: assert property (p_reset_clear) // [R13]
    else $error("Bank not clear after reset");
  property p_irq_cause;
    @(posedge sys_clk) disable iff (rst)
    irq_out |-> $past(|({gp_pin_flag, tach_flag, analog_input_flag} &
      ~{misc_source_irq_mask_reg[7], gp_pin_high_irq_mask_reg,
      gp_pin_low_irq_mask_reg, tach_irq_mask_reg, analog_input_irq_mask_reg})
      || |({chassis_intrusion, auto_fan_ctrl, thermal_limit_event,
      analog_input_8_flag, battery_flag, die_temp_flag} &
      ~{misc_source_irq_mask_reg[6], misc_source_irq_mask_reg[4:0]}));
  endproperty
  a_irq_cause: assert property (p_irq_cause) // [R14]
    else $error("Interrupt without an unmasked flag");
  property p_c_masked_flag;
    @(posedge sys_clk) disable iff (rst)
    (|tach_flag) && !irq_out;
  endproperty
  c_masked_flag: cover property (p_c_masked_flag);
  property p_c_temp_update;
    @(posedge sys_clk) disable iff (rst)
    corrected_temp_valid && die_temp_offset_reg != 8'h00;
  endproperty
  c_temp_update: cover property (p_c_temp_update);
  property p_c_irq_rise;
    @(posedge sys_clk) disable iff (rst)
    $rose(irq_out);
  endproperty
  c_irq_rise: cover property (p_c_irq_rise);
endmodule

// ### host_reg_model.sv
// Host side model driving the register port of the mask bank
module host_reg_model (
  // Clock
  input wire logic sys_clk,
  // Answer from the bank
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  input wire logic reg_addr_hit,
  // Request to the bank
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wdata,
  output logic reg_rd_en
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
  end

  // Idle bus shows the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // Fixed one-cycle answer, sampled mid-cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic h, output logic v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    @(negedge sys_clk);
    v = reg_rd_valid;
    d = reg_rdata;
    h = reg_addr_hit;
  endtask
endmodule

// ### tb_monitor_interrupt_mask_bank.sv
// Self-checking bench of the interrupt mask bank
`include "monitor_irq_cfg.svh"

module tb_monitor_interrupt_mask_bank;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr_en, reg_rd_en, reg_rd_valid, reg_addr_hit;
  logic [38:0] flags = '0;
  logic [7:0] raw_temp = 8'h00;
  logic raw_temp_valid = 1'b0;
  logic [7:0] corrected_temp;
  logic corrected_temp_valid, irq_out;
  int error_cnt = 0;
  int n_checks = 0;
  int seed = 32'h6555;
  int cyc = 0;
  logic [7:0] rd_d, mk [5];
  logic rd_h, rd_v;

  always #5 sys_clk = ~sys_clk;

  host_reg_model host (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .reg_addr_hit(reg_addr_hit),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en));

  monitor_interrupt_mask_bank uut (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .reg_addr_hit(reg_addr_hit),
    .analog_input_flag(flags[7:0]), .tach_flag(flags[15:8]),
    .die_temp_flag(flags[16]), .battery_flag(flags[17]),
    .analog_input_8_flag(flags[18]), .thermal_limit_event(flags[19]),
    .auto_fan_ctrl(flags[20]), .chassis_intrusion(flags[21]),
    .gp_pin_flag(flags[38:22]), .raw_temp(raw_temp),
    .raw_temp_valid(raw_temp_valid), .corrected_temp(corrected_temp),
    .corrected_temp_valid(corrected_temp_valid), .irq_out(irq_out));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(string nm, logic e, logic g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Mask register index and bit position of each source flag
  function automatic void src_mask(int i, output int r, output int b);
    if (i < 16) begin
      r = i / 8;
      b = i % 8;
    end else if (i < 22) begin
      r = 2;
      b = (i == 21) ? 6 : i - 16;
    end else if (i < 38) begin
      r = (i < 30) ? 3 : 4;
      b = (i - 22) % 8;
    end else begin
      r = 2;
      b = 7;
    end
  endfunction

  function automatic logic [7:0] sat_add(logic [7:0] a, logic [7:0] b);
    logic [8:0] s;
    s = {a[7], a} + {b[7], b};
    if (s[8] != s[7]) return s[8] ? 8'h80 : 8'h7f;
    return s[7:0];
  endfunction

  function automatic logic exp_irq(logic [38:0] f);
    int r, b;
    logic x;
    x = 1'b0;
    for (int i = 0; i < 39; i++) begin
      src_mask(i, r, b);
      x = x | (f[i] & ~mk[r][b]);
    end
    return x;
  endfunction

  task automatic set_masks();
    for (int r = 0; r < 5; r++) host.wr(8'h19 + r[7:0], mk[r]);
  endtask

  task automatic irq_check(string nm);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk_bit(nm, exp_irq(flags), irq_out);
  endtask

  task automatic temp_case(logic [7:0] r, logic [7:0] o);
    host.wr(`TEMP_OFFSET_OFS, o);
    raw_temp <= r;
    raw_temp_valid <= 1'b1;
    @(posedge sys_clk);
    raw_temp_valid <= 1'b0;
    raw_temp <= ~r;
    // Valid stands only in the cycle after the apply edge
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk_bit("temp_valid", 1'b1, corrected_temp_valid);
    chk_byte("corrected_temp", sat_add(r, o), corrected_temp);
    host.rd(`TEMP_READING_OFS, rd_d, rd_h, rd_v);
    chk_byte("reading_reg", sat_add(r, o), rd_d);
  endtask

  initial begin
    logic [7:0] d, e;
    int r, b;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values of the whole bank
    for (int a = 8'h19; a <= 8'h1f; a++) begin
      host.rd(a[7:0], rd_d, rd_h, rd_v);
      chk_byte("reset_value", `BANK_RESET_VAL, rd_d);
      chk_bit("rd_valid", 1'b1, rd_v);
      chk_bit("addr_hit", 1'b1, rd_h);
    end
    $display("test reset_values done");
    // All ones corner first, then random data
    for (int k = 0; k < 3; k++) begin
      for (int a = 8'h19; a <= 8'h1e; a++) begin
        d = (k == 0) ? 8'hff : 8'($random(seed));
        e = (a == `MISC_MASK_OFS) ? (d & `MISC_WRITABLE) : d;
        host.wr(a[7:0], d);
        host.rd(a[7:0], rd_d, rd_h, rd_v);
        chk_byte("readback", e, rd_d);
      end
    end
    // Read-only reading and the unmapped place 0x18
    host.wr(`TEMP_READING_OFS, 8'ha5);
    host.rd(`TEMP_READING_OFS, rd_d, rd_h, rd_v);
    chk_byte("ro_reading", 8'h00, rd_d);
    host.wr(8'h18, 8'h5a);
    host.rd(8'h18, rd_d, rd_h, rd_v);
    chk_byte("unmapped", 8'h00, rd_d);
    chk_bit("unmapped_hit", 1'b0, rd_h);
    $display("test register_access done");
    // Each source alone, masked then unmasked
    for (int i = 0; i < 39; i++) begin
      src_mask(i, r, b);
      foreach (mk[j]) mk[j] = 8'h00;
      mk[r] = 8'hff;
      set_masks();
      flags <= 39'h1 << i;
      irq_check("irq_masked");
      mk[r][b] = 1'b0;
      host.wr(8'h19 + r[7:0], mk[r]);
      irq_check("irq_open");
      flags <= '0;
      irq_check("irq_idle");
    end
    $display("test single_sources done");
    for (int k = 0; k < 25; k++) begin
      foreach (mk[j]) mk[j] = 8'($random(seed));
      set_masks();
      flags <= {7'($random(seed)), 32'($random(seed))};
      irq_check("irq_random");
    end
    flags <= '0;
    $display("test random_irq done");
    temp_case(8'h20, 8'hfe);
    temp_case(8'h7f, 8'h7f);
    temp_case(8'h80, 8'h80);
    for (int k = 0; k < 10; k++) begin
      temp_case(8'($random(seed)), 8'($random(seed)));
    end
    $display("test temperature done");
    print_verdict();
  end
endmodule
